// ===== hdl/modem_cfg_pkg.sv
// Constants of the modem sleep and address filter block.
// Assumes a 10 MHz sys_clk and a host that reaches settings through a command port.
// Function
// - Wake-up preamble length resets to 1 unit, a tenth of a second.
// - Accept packet if destination address AND mask equals own address or mask.
// - Otherwise discard; zero mask bits are don't-care positions.
// - Address mask is 16 bits, resets to all ones, meaning exact match.
// - Parity select takes codes 0 to 4, default 0.
// - Pin wake enabled and sleep pin low keeps the device fully awake.
// - After sleep pin asserts, stay active for idle time, then cyclic sleep.
// - Pin wake enable defaults 0 and acts only in cyclic sleep settings.
// - Load factory defaults restores settings without touching saved storage.
// - Request handshake enable defaults 0; 1 turns on request-to-send handshaking.
// - Stop bit count defaults 0; 0 one stop bit, 1 two stop bits.
// - Serial number readable as two read-only 16-bit words.
// - Sleep mode select takes 0 to 8, default 0; 3 to 8 cyclic.
// - Cyclic sleep wakes after interval; preamble found means receive after it.
// - Sleep after idle time with no activity; 100 ms units, 0x10..0xFFFF, reset 0x64.
// - Idle time applies only for cyclic or serial port sleep.
// - Firmware version readable as a read-only 16-bit value.
// - Save command copies all settings into persistent storage.
// - Preamble length is 8 bits up to 0xFF, in 100 ms units.
package modem_cfg_pkg;
	localparam logic [3:0]  ADDR_PREAMBLE    = 4'h0;
	localparam logic [3:0]  ADDR_MASK        = 4'h1;
	localparam logic [3:0]  ADDR_PARITY      = 4'h2;
	localparam logic [3:0]  ADDR_PIN_WAKE    = 4'h3;
	localparam logic [3:0]  ADDR_HANDSHAKE   = 4'h4;
	localparam logic [3:0]  ADDR_STOP_BITS   = 4'h5;
	localparam logic [3:0]  ADDR_SERIAL_HI   = 4'h6;
	localparam logic [3:0]  ADDR_SERIAL_LO   = 4'h7;
	localparam logic [3:0]  ADDR_SLEEP_MODE  = 4'h8;
	localparam logic [3:0]  ADDR_IDLE_TIME   = 4'h9;
	localparam logic [3:0]  ADDR_FW_VERSION  = 4'hA;
	localparam logic [3:0]  ADDR_DEST        = 4'hB;

	localparam logic [7:0]  RST_PREAMBLE     = 8'h01;
	localparam logic [15:0] RST_MASK         = 16'hFFFF;
	localparam logic [7:0]  RST_PARITY       = 8'h00;
	localparam logic [7:0]  RST_PIN_WAKE     = 8'h00;
	localparam logic [7:0]  RST_HANDSHAKE    = 8'h00;
	localparam logic [7:0]  RST_STOP_BITS    = 8'h00;
	localparam logic [7:0]  RST_SLEEP_MODE   = 8'h00;
	localparam logic [15:0] RST_IDLE_TIME    = 16'h0064;
	localparam logic [15:0] RST_DEST         = 16'h0000;

	localparam logic [7:0]  MAX_PARITY       = 8'h04;
	localparam logic [7:0]  MAX_FLAG         = 8'h01;
	localparam logic [7:0]  MAX_SLEEP_MODE   = 8'h08;
	localparam logic [15:0] MIN_IDLE_TIME    = 16'h0010;

	localparam logic [7:0]  SM_NONE          = 8'h00;
	localparam logic [7:0]  SM_PIN           = 8'h01;
	localparam logic [7:0]  SM_SERIAL        = 8'h02;
	localparam logic [7:0]  SM_CYCLIC_FIRST  = 8'h03;

	localparam int          CLK_HZ           = 10000000;
	localparam int          TICK_MS          = 100;
	localparam int          TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;

	typedef enum logic [3:0] {
		ST_ACTIVE = 4'b0001,
		ST_SLEEP  = 4'b0010,
		ST_LISTEN = 4'b0100,
		ST_SYNC   = 4'b1000
	} power_state_t;
endpackage

// ===== hdl/modem_sleep_and_address_filter.sv
// Settings store, packet address filter and sleep controller of the modem.
// Assumes one 10 MHz clock and a command port driven by the host side logic.
`timescale 1ns/1ps
module modem_sleep_and_address_filter #(
	parameter int          TICK_CYC   = modem_cfg_pkg::TICK_CYCLES,
	parameter logic [15:0] SERIAL_HI  = 16'h1234,  // Arbitrary value
	parameter logic [15:0] SERIAL_LO  = 16'h5678,  // Arbitrary value
	parameter logic [15:0] FW_VERSION = 16'h0100   // Arbitrary value
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// Command port
	input  wire logic        cmd_wr,
	input  wire logic        cmd_rd,
	input  wire logic [3:0]  cmd_addr,
	input  wire logic [15:0] cmd_wdata,
	input  wire logic        cmd_defaults,
	input  wire logic        cmd_save,
	output logic      [15:0] cmd_rdata,
	output logic             cmd_rvalid,
	output logic             cmd_err,
	// Packet filter
	input  wire logic        pkt_valid,
	input  wire logic [15:0] pkt_dest,
	output logic             pkt_accept,
	output logic             pkt_discard,
	// Sleep control
	input  wire logic        sleep_pin,
	input  wire logic        activity,
	input  wire logic        preamble_seen,
	input  wire logic        preamble_end,
	input  wire logic        tx_pending,
	output logic             asleep,
	output logic             rx_enable,
	// Serial framing outputs
	output logic      [2:0]  parity_mode,
	output logic             two_stop_bits,
	output logic             rts_enable
);
	import modem_cfg_pkg::*;

	logic [7:0]   preamble_q;
	logic [15:0]  mask_q;
	logic [7:0]   parity_q;
	logic [7:0]   pin_wake_q;
	logic [7:0]   handshake_q;
	logic [7:0]   stop_q;
	logic [7:0]   sleep_mode_q;
	logic [15:0]  idle_time_q;
	logic [15:0]  dest_q;
	// Persistent copy, reloaded on reset so defaults only live until reset
	logic [95:0]  saved_q;
	logic [95:0]  live_d;
	logic         saved_valid_q;
	logic         reload_q;
	logic         wr_ok;
	logic [23:0]  tick_cnt_q;
	logic         tick_q;
	logic [15:0]  idle_cnt_q;
	logic [15:0]  cyc_cnt_q;
	power_state_t state_q;
	logic         cyclic;
	logic         pin_hold;
	logic         idle_done;

	function automatic logic [15:0] cyclic_units(input logic [7:0] mode);
		logic [15:0] u;
		u = 16'h0005;
		if (mode > SM_CYCLIC_FIRST)
			u = 16'h000A << (mode - 8'h04);
		return u;
	endfunction

	function automatic logic range_ok(input logic [3:0] a, input logic [15:0] v);
		logic ok;
		ok = 1'b0;
		case (a)
			ADDR_PREAMBLE:   ok = (v[15:8] == 8'h00);
			ADDR_MASK:       ok = 1'b1;
			ADDR_DEST:       ok = 1'b1;
			ADDR_PARITY:     ok = (v <= {8'h00, MAX_PARITY});
			ADDR_PIN_WAKE:   ok = (v <= {8'h00, MAX_FLAG});
			ADDR_HANDSHAKE:  ok = (v <= {8'h00, MAX_FLAG});
			ADDR_STOP_BITS:  ok = (v <= {8'h00, MAX_FLAG});
			ADDR_SLEEP_MODE: ok = (v <= {8'h00, MAX_SLEEP_MODE});
			ADDR_IDLE_TIME:  ok = (v >= MIN_IDLE_TIME);
			default:         ok = 1'b0;
		endcase
		return ok;
	endfunction

	assign wr_ok = cmd_wr && range_ok(cmd_addr, cmd_wdata);
	assign live_d = {preamble_q, mask_q, parity_q, pin_wake_q, handshake_q, stop_q, sleep_mode_q,
		idle_time_q, dest_q};

	// Settings; defaults command wins over a write in the same cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			preamble_q   <= RST_PREAMBLE;
			mask_q       <= RST_MASK;
			parity_q     <= RST_PARITY;
			pin_wake_q   <= RST_PIN_WAKE;
			handshake_q  <= RST_HANDSHAKE;
			stop_q       <= RST_STOP_BITS;
			sleep_mode_q <= RST_SLEEP_MODE;
			idle_time_q  <= RST_IDLE_TIME;
			dest_q       <= RST_DEST;
		end else if (reload_q && saved_valid_q) begin
			{preamble_q, mask_q, parity_q, pin_wake_q, handshake_q, stop_q, sleep_mode_q,
				idle_time_q, dest_q} <= saved_q;
		end else if (cmd_defaults) begin
			preamble_q   <= RST_PREAMBLE;
			mask_q       <= RST_MASK;
			parity_q     <= RST_PARITY;
			pin_wake_q   <= RST_PIN_WAKE;
			handshake_q  <= RST_HANDSHAKE;
			stop_q       <= RST_STOP_BITS;
			sleep_mode_q <= RST_SLEEP_MODE;
			idle_time_q  <= RST_IDLE_TIME;
			dest_q       <= RST_DEST;
		end else if (wr_ok) begin
			case (cmd_addr)
				ADDR_PREAMBLE:   preamble_q   <= cmd_wdata[7:0];
				ADDR_MASK:       mask_q       <= cmd_wdata;
				ADDR_PARITY:     parity_q     <= cmd_wdata[7:0];
				ADDR_PIN_WAKE:   pin_wake_q   <= cmd_wdata[7:0];
				ADDR_HANDSHAKE:  handshake_q  <= cmd_wdata[7:0];
				ADDR_STOP_BITS:  stop_q       <= cmd_wdata[7:0];
				ADDR_SLEEP_MODE: sleep_mode_q <= cmd_wdata[7:0];
				ADDR_IDLE_TIME:  idle_time_q  <= cmd_wdata;
				ADDR_DEST:       dest_q       <= cmd_wdata;
				default: ;
			endcase
		end
	end

	// Persistent store has no reset so it outlives nrst; a blank store must hold its flag clear
	always_ff @(posedge sys_clk) begin
		if (cmd_save) begin
			saved_q       <= live_d;
			saved_valid_q <= 1'b1;
		end
	end

	// High only on the first edge after reset, when the stored copy is pulled back in
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			reload_q <= 1'b1;
		else
			reload_q <= 1'b0;
	end

	// Read port: one cycle after cmd_rd
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_rdata  <= 16'h0000;
			cmd_rvalid <= 1'b0;
			cmd_err    <= 1'b0;
		end else begin
			cmd_rvalid <= cmd_rd;
			cmd_err    <= cmd_wr && !wr_ok;
			if (cmd_rd) begin
				case (cmd_addr)
					ADDR_PREAMBLE:   cmd_rdata <= {8'h00, preamble_q};
					ADDR_MASK:       cmd_rdata <= mask_q;
					ADDR_PARITY:     cmd_rdata <= {8'h00, parity_q};
					ADDR_PIN_WAKE:   cmd_rdata <= {8'h00, pin_wake_q};
					ADDR_HANDSHAKE:  cmd_rdata <= {8'h00, handshake_q};
					ADDR_STOP_BITS:  cmd_rdata <= {8'h00, stop_q};
					ADDR_SERIAL_HI:  cmd_rdata <= SERIAL_HI;
					ADDR_SERIAL_LO:  cmd_rdata <= SERIAL_LO;
					ADDR_SLEEP_MODE: cmd_rdata <= {8'h00, sleep_mode_q};
					ADDR_IDLE_TIME:  cmd_rdata <= idle_time_q;
					ADDR_FW_VERSION: cmd_rdata <= FW_VERSION;
					ADDR_DEST:       cmd_rdata <= dest_q;
					default:         cmd_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// Address filter, answer one cycle after pkt_valid
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pkt_accept  <= 1'b0;
			pkt_discard <= 1'b0;
		end else begin
			pkt_accept  <= pkt_valid && (((pkt_dest & mask_q) == dest_q)
				|| ((pkt_dest & mask_q) == mask_q));
			pkt_discard <= pkt_valid && ((pkt_dest & mask_q) != dest_q)
				&& ((pkt_dest & mask_q) != mask_q);
		end
	end

	// 100 ms tick
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt_q <= 24'h000000;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == 24'(TICK_CYC - 1)) begin
			tick_cnt_q <= 24'h000000;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 24'h000001;
			tick_q     <= 1'b0;
		end
	end

	assign cyclic    = sleep_mode_q >= SM_CYCLIC_FIRST;
	assign pin_hold  = cyclic && pin_wake_q[0] && !sleep_pin;
	assign idle_done = idle_cnt_q >= idle_time_q;

	// Idle counter in ticks
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			idle_cnt_q <= 16'h0000;
		else if (activity || pin_hold || state_q != ST_ACTIVE)
			idle_cnt_q <= 16'h0000;
		else if (tick_q && !idle_done)
			idle_cnt_q <= idle_cnt_q + 16'h0001;
	end

	// Power state machine
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q   <= ST_ACTIVE;
			cyc_cnt_q <= 16'h0000;
		end else begin
			case (state_q)
				ST_ACTIVE: begin
					cyc_cnt_q <= 16'h0000;
					if ((cyclic || sleep_mode_q == SM_SERIAL) && idle_done && !tx_pending && !pin_hold)
						state_q <= ST_SLEEP;
				end
				ST_SLEEP: begin
					if (pin_hold || tx_pending || !cyclic && sleep_mode_q != SM_SERIAL)
						state_q <= ST_ACTIVE;
					else if (cyclic && tick_q) begin
						if (cyc_cnt_q + 16'h0001 >= cyclic_units(sleep_mode_q)) begin
							state_q   <= ST_LISTEN;
							cyc_cnt_q <= 16'h0000;
						end else
							cyc_cnt_q <= cyc_cnt_q + 16'h0001;
					end
				end
				ST_LISTEN: begin
					if (preamble_seen)
						state_q <= ST_SYNC;
					else if (pin_hold || tx_pending)
						state_q <= ST_ACTIVE;
					else if (tick_q)
						state_q <= ST_SLEEP;
				end
				ST_SYNC: begin
					if (preamble_end)
						state_q <= ST_ACTIVE;
				end
				default: state_q <= ST_ACTIVE;
			endcase
		end
	end

	assign asleep        = state_q == ST_SLEEP;
	assign rx_enable     = state_q == ST_ACTIVE;

	// Framing outputs from flops
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			parity_mode   <= 3'h0;
			two_stop_bits <= 1'b0;
			rts_enable    <= 1'b0;
		end else begin
			parity_mode   <= parity_q[2:0];
			two_stop_bits <= stop_q[0];
			rts_enable    <= handshake_q[0];
		end
	end

	a_filter_accept: assert property (@(posedge sys_clk) disable iff (!nrst)
		pkt_valid && ((pkt_dest & mask_q) == dest_q) |=> pkt_accept && !pkt_discard)
		else $error("matching packet not accepted");
	a_filter_discard: assert property (@(posedge sys_clk) disable iff (!nrst)
		pkt_valid && ((pkt_dest & mask_q) != dest_q) && ((pkt_dest & mask_q) != mask_q)
		|=> pkt_discard && !pkt_accept)
		else $error("mismatching packet not discarded");
	a_pin_hold_awake: assert property (@(posedge sys_clk) disable iff (!nrst)
		pin_hold && state_q == ST_ACTIVE |=> state_q == ST_ACTIVE)
		else $error("slept while pin wake held");
	a_bad_write_kept: assert property (@(posedge sys_clk) disable iff (!nrst)
		cmd_wr && cmd_addr == ADDR_SLEEP_MODE && cmd_wdata > 16'h0008 && !cmd_defaults && !reload_q
		|=> sleep_mode_q == $past(sleep_mode_q) && cmd_err)
		else $error("out of range sleep mode stored");
	a_idle_min_kept: assert property (@(posedge sys_clk) disable iff (!nrst)
		cmd_wr && cmd_addr == ADDR_IDLE_TIME && cmd_wdata < 16'h0010 && !cmd_defaults && !reload_q
		|=> idle_time_q == $past(idle_time_q))
		else $error("idle time below minimum stored");
	a_defaults_load: assert property (@(posedge sys_clk) disable iff (!nrst)
		cmd_defaults && !reload_q
		|=> mask_q == 16'hFFFF && preamble_q == 8'h01 && idle_time_q == 16'h0064)
		else $error("defaults not restored");
	a_no_sleep_mode0: assert property (@(posedge sys_clk) disable iff (!nrst)
		sleep_mode_q == SM_NONE && state_q == ST_ACTIVE |=> state_q == ST_ACTIVE)
		else $error("slept with sleep disabled");
	sequence s_preamble_sync;
		state_q == ST_LISTEN && preamble_seen ##1 state_q == ST_SYNC;
	endsequence
	sequence s_preamble_done;
		state_q == ST_SYNC && preamble_end;
	endsequence
	a_preamble_sync: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_preamble_sync |-> !rx_enable)
		else $error("receive opened before preamble end");
	a_sync_release: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_preamble_done |=> rx_enable)
		else $error("receive not opened at preamble end");
	a_tick_period: assert property (@(posedge sys_clk) disable iff (!nrst)
		tick_q |=> !tick_q [*2])
		else $error("tick too frequent");
endmodule

// ===== tb/host_cmd_model.sv
// Host controller model that drives the modem command port.
// Assumes the block takes a strobe at a sys_clk edge and answers one cycle later.
`timescale 1ns/1ps
module host_cmd_model (
	// Clock
	input  wire logic        sys_clk,
	// Command port
	output logic             cmd_wr,
	output logic             cmd_rd,
	output logic      [3:0]  cmd_addr,
	output logic      [15:0] cmd_wdata,
	output logic             cmd_defaults,
	output logic             cmd_save,
	input  wire logic [15:0] cmd_rdata,
	input  wire logic        cmd_rvalid,
	input  wire logic        cmd_err
);
	initial begin
		cmd_wr       = 1'b0;
		cmd_rd       = 1'b0;
		cmd_addr     = 4'h0;
		cmd_wdata    = 16'h0000;
		cmd_defaults = 1'b0;
		cmd_save     = 1'b0;
	end

	// Released lines show the inverse so a stale value is never mistaken for a live one
	task automatic wr(input logic [3:0] a, input logic [15:0] d, output logic e);
		@(posedge sys_clk);
		cmd_wr    <= 1'b1;
		cmd_addr  <= a;
		cmd_wdata <= d;
		@(posedge sys_clk);
		cmd_wr    <= 1'b0;
		cmd_addr  <= ~a;
		cmd_wdata <= ~d;
		#1 e = cmd_err;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		cmd_rd   <= 1'b1;
		cmd_addr <= a;
		@(posedge sys_clk);
		cmd_rd   <= 1'b0;
		cmd_addr <= ~a;
		#1 d = (cmd_rvalid === 1'b1) ? cmd_rdata : 16'hXXXX;
	endtask

	// One-cycle pulse of save (sv=1) or load defaults (sv=0)
	task automatic pulse(input logic sv);
		@(posedge sys_clk);
		cmd_save     <= sv;
		cmd_defaults <= ~sv;
		@(posedge sys_clk);
		cmd_save     <= 1'b0;
		cmd_defaults <= 1'b0;
	endtask
endmodule

// ===== tb/modem_sleep_and_address_filter_tb.sv
// Self-checking bench of the modem settings, address filter and sleep control.
// Assumes the host model above and a short tick of 10 cycles.
`timescale 1ns/1ps
module modem_sleep_and_address_filter_tb;
	import modem_cfg_pkg::*;
	localparam logic [15:0] SHI = 16'hA5A5;  // Arbitrary value
	localparam logic [15:0] SLO = 16'h5A5A;  // Arbitrary value
	localparam logic [15:0] FWV = 16'h0C3E;  // Arbitrary value
	logic        sys_clk, nrst, cmd_wr, cmd_rd, cmd_defaults, cmd_save, cmd_rvalid, cmd_err;
	logic [3:0]  cmd_addr;
	logic [15:0] cmd_wdata, cmd_rdata, pkt_dest, v;
	logic        pkt_valid, pkt_accept, pkt_discard, sleep_pin, activity, preamble_seen, preamble_end;
	logic        tx_pending, asleep, rx_enable, two_stop_bits, rts_enable, e;
	logic [2:0]  parity_mode;
	int          fails, samples_checked, i;
	logic [15:0] rst_tab [13] = '{16'h0001, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, SHI, SLO,
		16'h0000, 16'h0064, FWV, 16'h0000, 16'h0000};
	logic [3:0]  w_a [10] = '{4'h2, 4'h2, 4'h8, 4'h9, 4'h9, 4'h3, 4'h0, 4'h0, 4'h6, 4'hF};
	logic [15:0] w_d [10] = '{16'h0005, 16'h0004, 16'h0009, 16'h000F, 16'h0010, 16'h0002, 16'h00FF,
		16'h0100, 16'h0000, 16'h0001};
	logic        w_e [10] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	logic [15:0] w_r [10] = '{16'h0000, 16'h0004, 16'h0000, 16'h0064, 16'h0010, 16'h0000, 16'h00FF,
		16'h00FF, SHI, 16'h0000};

	host_cmd_model host (.sys_clk(sys_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_defaults(cmd_defaults), .cmd_save(cmd_save),
		.cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .cmd_err(cmd_err));

	modem_sleep_and_address_filter #(.TICK_CYC(10), .SERIAL_HI(SHI), .SERIAL_LO(SLO), .FW_VERSION(FWV)) DUT (
		.sys_clk(sys_clk), .nrst(nrst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_defaults(cmd_defaults), .cmd_save(cmd_save), .cmd_rdata(cmd_rdata),
		.cmd_rvalid(cmd_rvalid), .cmd_err(cmd_err), .pkt_valid(pkt_valid), .pkt_dest(pkt_dest),
		.pkt_accept(pkt_accept), .pkt_discard(pkt_discard), .sleep_pin(sleep_pin), .activity(activity),
		.preamble_seen(preamble_seen), .preamble_end(preamble_end), .tx_pending(tx_pending),
		.asleep(asleep), .rx_enable(rx_enable), .parity_mode(parity_mode),
		.two_stop_bits(two_stop_bits), .rts_enable(rts_enable));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic pkt(input logic [15:0] d, input logic acc);
		@(posedge sys_clk);
		pkt_valid <= 1'b1;
		pkt_dest  <= d;
		@(posedge sys_clk);
		pkt_valid <= 1'b0;
		pkt_dest  <= ~d;
		#1 chk("accept", 16'(pkt_accept), 16'(acc));
		chk("discard", 16'(pkt_discard), 16'(!acc));
	endtask

	// Waits at most n cycles for asleep to reach lvl, sampling after the edge has settled
	task automatic wait_for(input logic lvl, input int n);
		for (int k = 0; k < n && asleep !== lvl; k++) begin
			@(posedge sys_clk);
			#1;
		end
	endtask

	task automatic pulse_in(input int w);
		@(posedge sys_clk);
		if (w == 0) activity <= 1'b1; else if (w == 1) preamble_seen <= 1'b1; else preamble_end <= 1'b1;
		@(posedge sys_clk);
		{activity, preamble_seen, preamble_end} <= 3'b000;
	endtask

	initial begin
		#2_000_000;
		fails++;
		wrap_up();
	end

	initial begin
		fails = 0;
		samples_checked = 0;
		nrst = 1'b0;
		{pkt_valid, activity, preamble_seen, preamble_end, tx_pending} = 5'b00000;
		pkt_dest = 16'h0000;
		sleep_pin = 1'b1;
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		for (i = 0; i < 13; i++) begin
			host.rd(i[3:0], v);
			chk("reset value", v, rst_tab[i]);
		end
		for (i = 0; i < 10; i++) begin
			host.wr(w_a[i], w_d[i], e);
			chk("write refused", 16'(e), 16'(w_e[i]));
			host.rd(w_a[i], v);
			chk("readback", v, w_r[i]);
		end
		for (i = 0; i <= 4; i++) begin
			host.wr(ADDR_PARITY, i[15:0], e);
			@(posedge sys_clk);
			#1 chk("parity_mode", 16'(parity_mode), 16'(i[2:0]));
		end
		host.wr(ADDR_STOP_BITS, 16'h0001, e);
		host.wr(ADDR_HANDSHAKE, 16'h0001, e);
		@(posedge sys_clk);
		#1 chk("two_stop_bits", 16'(two_stop_bits), 16'h0001);
		chk("rts_enable", 16'(rts_enable), 16'h0001);
		host.pulse(1'b1);
		host.pulse(1'b0);
		host.rd(ADDR_PARITY, v);
		chk("parity after defaults", v, 16'(RST_PARITY));
		@(posedge sys_clk);
		#1 chk("rts after defaults", 16'(rts_enable), 16'h0000);
		pkt(16'h0000, 1'b1);
		pkt(16'h0001, 1'b0);
		host.wr(ADDR_MASK, 16'h00F0, e);
		host.wr(ADDR_DEST, 16'h0030, e);
		pkt(16'h1234, 1'b1);
		pkt(16'h00F0, 1'b1);
		pkt(16'hFF40, 1'b0);
		for (i = 0; i <= 8; i++) begin
			host.wr(ADDR_SLEEP_MODE, i[15:0], e);
			chk("sleep mode write", 16'(e), 16'h0000);
		end
		host.wr(ADDR_SLEEP_MODE, 16'h0000, e);
		wait_for(1'b1, 300);
		chk("no sleep mode", 16'(asleep), 16'h0000);
		host.wr(ADDR_IDLE_TIME, 16'h0010, e);
		host.wr(ADDR_PREAMBLE, 16'h0006, e);
		// The idle count runs in every mode, so restart it before a sleep mode is chosen
		pulse_in(0);
		host.wr(ADDR_SLEEP_MODE, 16'h0003, e);
		wait_for(1'b1, 140);
		chk("awake before idle time", 16'(asleep), 16'h0000);
		wait_for(1'b1, 40);
		chk("asleep after idle time", 16'(asleep), 16'h0001);
		wait_for(1'b0, 70);
		chk("wake after interval", 16'(asleep), 16'h0000);
		pulse_in(1);
		pulse_in(2);
		#1 chk("receiving after preamble", 16'(rx_enable), 16'h0001);
		host.wr(ADDR_PIN_WAKE, 16'h0001, e);
		sleep_pin <= 1'b0;
		pulse_in(0);
		wait_for(1'b1, 300);
		chk("pin hold awake", 16'(asleep), 16'h0000);
		sleep_pin <= 1'b1;
		wait_for(1'b1, 140);
		chk("awake after pin release", 16'(asleep), 16'h0000);
		wait_for(1'b1, 40);
		chk("sleep after pin release", 16'(asleep), 16'h0001);
		tx_pending <= 1'b1;
		wait_for(1'b0, 3);
		chk("wake on pending data", 16'(asleep), 16'h0000);
		tx_pending <= 1'b0;
		// Second reset: settings return from the stored copy, not the factory values
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		host.rd(ADDR_PARITY, v);
		chk("parity after reset", v, 16'h0004);
		host.rd(ADDR_PREAMBLE, v);
		chk("preamble after reset", v, 16'h00FF);
		host.rd(ADDR_SLEEP_MODE, v);
		chk("sleep mode after reset", v, 16'h0000);
		@(posedge sys_clk);
		#1 chk("rts after reset", 16'(rts_enable), 16'h0001);
		wrap_up();
	end
endmodule
